// ---- bench/scp_host.sv ----
// Purpose: Controller model driving select, serial clock and data.
// Assumes: Bit period of 32 ref_clk cycles, 160 ns.
// Notes:   Phases scaled down from the documented microseconds.
module scp_host (
    input  wire logic ref_clk,
    input  wire logic busy,
    input  wire logic sdo,
    output logic      sel_n,
    output logic      sclk,
    output logic      sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    // Lines rest with select released and the clock low
    initial begin
        sel_n = 1'b1;
        sclk  = 1'b0;
        sdi   = 1'b0;
    end
    // One whole command per frame; en low keeps select released
    task automatic xfer(input logic [127:0] tx, input int nb, input bit en,
                        output logic [127:0] rx);
        rx = '0;
        @(posedge ref_clk) sel_n <= !en;
        repeat (16) @(posedge ref_clk);
        for (int i = 0; i < nb; i++) begin
            sdi <= tx[127-i];
            repeat (8) @(posedge ref_clk);
            sclk <= 1'b1;
            repeat (16) @(posedge ref_clk);
            sclk <= 1'b0;
            rx[127-i] = sdo;
            repeat (8) @(posedge ref_clk);
        end
        sdi <= ~sdi;
        repeat (8) @(posedge ref_clk);
        sel_n <= 1'b1;
    endtask : xfer
    // Wait for busy low under a bound
    task automatic idle(output bit ok);
        repeat (16) @(posedge ref_clk);
        for (int k = 0; k < 2000 && busy !== 1'b0; k++) begin
            @(posedge ref_clk);
        end
        ok = (busy === 1'b0);
    endtask : idle
endmodule : scp_host

// ---- bench/scp_port_props.sv ----
// Purpose: Timing checks on the serial command port pins.
// Assumes: One clock domain, ref_clk, async active-low resetn.
// Notes:   HK_CYCLES follows the instance through the bind.
module scp_port_props #(
    parameter int HK_CYCLES = 8
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic pll_locked,
    input wire logic busy,
    input wire logic sdo,
    input wire logic lock,
    input wire logic freq_load
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BUSY_MAX = HK_CYCLES + 12;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    // Pin-level timing of select, handshake, busy and lock
    property p_busy_sel; (!sel_n)[*6] |-> busy; endproperty
    a_busy_sel: assert property (p_busy_sel)
        else $error("busy low while selected");
    property p_hs_rise; $fell(sel_n) && !busy |-> ##[3:5] sdo; endproperty
    a_hs_rise: assert property (p_hs_rise)
        else $error("no handshake");
    property p_hs_hold; $fell(sel_n) && !busy |-> ##6 sdo[*8]; endproperty
    a_hs_hold: assert property (p_hs_hold)
        else $error("handshake dropped");
    property p_release; $rose(sel_n) |-> ##5 (!sdo)[*3]; endproperty
    a_release: assert property (p_release)
        else $error("sdo high after release");
    property p_idle; sel_n[*6] |-> !sdo; endproperty
    a_idle: assert property (p_idle)
        else $error("sdo moves while deselected");
    property p_hk; $rose(sel_n) |-> busy[*6] ##[0:BUSY_MAX] !busy; endproperty
    a_hk: assert property (p_hk)
        else $error("busy span wrong");
    property p_load; freq_load |-> sel_n && busy ##1 !freq_load; endproperty
    a_load: assert property (p_load)
        else $error("bad load pulse");
    property p_lock_hi; pll_locked[*3] |-> lock; endproperty
    a_lock_hi: assert property (p_lock_hi)
        else $error("lock low");
    property p_lock_lo; (!pll_locked)[*3] |-> !lock; endproperty
    a_lock_lo: assert property (p_lock_lo)
        else $error("lock high");
    property p_sync; $rose(sclk) && !sel_n |-> ##1 $stable(sdo)[*2]; endproperty
    a_sync: assert property (p_sync)
        else $error("sdo before sync");
endmodule : scp_port_props

bind scp_port scp_port_props #(.HK_CYCLES(HK_CYCLES)) u_props (
    .ref_clk(ref_clk), .resetn(resetn), .sel_n(sel_n), .sclk(sclk),
    .pll_locked(pll_locked), .busy(busy), .sdo(sdo), .lock(lock),
    .freq_load(freq_load));

// ---- bench/scp_port_test.sv ----
// Purpose: Self-checking bench of the serial command port.
// Assumes: HK_CYCLES shortened to 8 for run time.
// Notes:   Random values from a fixed xorshift seed.
module scp_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       ref_clk, resetn, pll_locked;
    logic                       sel_n, sclk, sdi, busy, sdo, lock, freq_load;
    logic [7:0]                 status_bits, temp_char;
    logic [scp_pkg::FREQ_W-1:0] freq_hz;
    logic [31:0]                seed;
    logic [63:0]                m, f, last;
    logic [127:0]               rx;
    string                      s;
    bit                         ok;
    int                         err_total, num_checks, loads, n;

    scp_port #(.HK_CYCLES(8)) dut (.ref_clk(ref_clk), .resetn(resetn),
        .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .pll_locked(pll_locked),
        .status_bits(status_bits), .temp_char(temp_char), .busy(busy),
        .sdo(sdo), .lock(lock), .freq_hz(freq_hz), .freq_load(freq_load));
    scp_host host (.ref_clk(ref_clk), .busy(busy), .sdo(sdo),
        .sel_n(sel_n), .sclk(sclk), .sdi(sdi));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : rnd
    function automatic logic [127:0] pack(input string t);
        logic [127:0] b;
        b = '0;
        for (int i = 0; i < t.len(); i++) b[127-8*i -: 8] = t[i];
        return b;
    endfunction : pack
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic frame(input logic [127:0] tx, input int nb, input bit en);
        host.xfer(tx, nb, en, rx);
        host.idle(ok);
        check(64'(ok), 64'h1);
    endtask : frame
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////
    // Clock, load pulse count and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (freq_load === 1'b1) loads++;
    initial begin
        repeat (50000) @(posedge ref_clk); // Tests need about 33k cycles
        err_total++;
        stop_test();
    end
    // Main sequence
    initial begin
        resetn = 1'b0;
        pll_locked = 1'b0;
        status_bits = 8'h00;
        temp_char = 8'h00;
        seed = 32'h6670;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Frequencies: known value, 16-char string, random, either case
        for (int k = 0; k < 6; k++) begin
            seed = rnd(seed);
            m = (k == 0) ? 64'd8000 : (k == 1) ? 64'd12 : 64'(seed % 100000);
            f = (k == 0) ? 64'd100000 : 64'(seed[30:11] % 1000000);
            if (k == 1)
                s = $sformatf("f%08d.%06d", m, f);
            else
                s = $sformatf("%s%0d.%06d", k[0] ? "f" : "F", m, f);
            n = loads;
            frame(pack(s), 8 * s.len(), 1'b1);
            check(64'(freq_hz), m * 64'd1000000 + f);
            check(64'(loads), 64'(n + 1));
            pll_locked <= seed[3];
            status_bits <= seed[15:8];
            temp_char <= seed[23:16];
        end
        $display("Frequency tests done");
        // Trailing partial character is left out of the command
        n = loads;
        frame(pack("F5"), 19, 1'b1);
        check(64'(freq_hz), 64'd5000000);
        check(64'(loads), 64'(n + 1));
        // Unknown, malformed, then a frame clocked without select
        n = loads;
        last = 64'(freq_hz);
        frame(pack("X12"), 24, 1'b1);
        frame(pack("F7.5.1"), 48, 1'b1);
        frame(pack("F1"), 16, 1'b0);
        check(64'(loads), 64'(n));
        check(64'(freq_hz), last);
        $display("Ignore tests done");
        // Status and temperature reads with 16 null bytes
        for (int k = 0; k < 2; k++) begin
            frame(pack(k ? "t" : "?"), 8, 1'b1);
            frame('0, 128, 1'b1);
            check(64'(rx[127:120]), 64'(k ? temp_char : status_bits));
            check(64'(rx[119:56]), 64'h0);
            check(64'(lock), 64'(pll_locked));
        end
        $display("Read tests done");
        stop_test();
    end
endmodule : scp_port_test

// ---- hdl/scp_pkg.sv ----
// Purpose: Shared constants and types of the serial command port.
// Assumes: ref_clk at 200 MHz; link lines asynchronous to it.
// Notes:   Command interpretation sits in the main module.
package scp_pkg;

    localparam int          MAX_CHARS   = 16;
    localparam int          CHAR_W      = 8;
    localparam int          BUF_W       = MAX_CHARS * CHAR_W;
    localparam int          BITCNT_W    = 8;
    localparam int          FRAC_DIGITS = 6;
    localparam int          FREQ_W      = 48;
    localparam int          SYNC_STAGES = 2;
    localparam int          CLK_MHZ     = 200;
    localparam int          HK_TIME_NS  = 1000;
    localparam int          HK_CYCLES   = (HK_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  CH_F        = 8'h46;
    localparam logic [7:0]  CH_T        = 8'h54;
    localparam logic [7:0]  CH_Q        = 8'h3F;
    localparam logic [7:0]  CH_DOT      = 8'h2E;
    localparam logic [7:0]  CH_ZERO     = 8'h30;
    localparam logic [7:0]  CH_NINE     = 8'h39;
    localparam logic [7:0]  CASE_BIT    = 8'h20;
    localparam logic [7:0]  CH_A_LO     = 8'h61;
    localparam logic [7:0]  CH_Z_LO     = 8'h7A;
    localparam logic [47:0] HZ_PER_MHZ  = 48'h0000_000F_4240;

    // Synchronised link samples
    typedef struct packed {
        logic sel;    // Select, active high after inversion
        logic sclk;
        logic sdi;
    } scp_link_t;

    // Result of one interpreted command
    typedef struct packed {
        logic              freq_valid;
        logic [FREQ_W-1:0] freq_hz;
        logic              reply_valid;
        logic [BUF_W-1:0]  reply;
    } scp_cmd_t;

endpackage : scp_pkg

// ---- hdl/scp_port.sv ----
// Purpose: Serial command port with busy handshake and reply buffer.
// Assumes: Controller keeps the link timing; lines arrive asynchronous.
// Notes:   Handles frequency, status and temperature commands only.
module scp_port #(
    parameter int HK_CYCLES = scp_pkg::HK_CYCLES
) (
    input  wire logic                      ref_clk,
    input  wire logic                      resetn,
    input  wire logic                      sel_n,
    input  wire logic                      sclk,
    input  wire logic                      sdi,
    input  wire logic                      pll_locked,
    input  wire logic [7:0]                status_bits,
    input  wire logic [7:0]                temp_char,
    output logic                           busy,
    output logic                           sdo,
    output logic                           lock,
    output logic [scp_pkg::FREQ_W-1:0]     freq_hz,
    output logic                           freq_load
);

    ////////////////////////////////////////////////////////////////////
    // Receive, interpret, then housekeeping before the next select
    typedef enum logic [1:0] {
        SCP_IDLE = 2'b00,
        SCP_RECV = 2'b01,
        SCP_EXEC = 2'b10,
        SCP_HK   = 2'b11
    } scp_state_t;

    // Fold lower-case letters to upper case
    function automatic logic [7:0] scp_upper(input logic [7:0] c);
        if (c >= scp_pkg::CH_A_LO && c <= scp_pkg::CH_Z_LO) begin
            return c & ~scp_pkg::CASE_BIT;
        end
        return c;
    endfunction : scp_upper

    // Parse F<MHz>[.<frac>] into Hz; rejects malformed strings
    function automatic scp_pkg::scp_cmd_t scp_decode(
        input logic [scp_pkg::BUF_W-1:0]    buf_in,
        input logic [scp_pkg::BITCNT_W-1:0] nbits,
        input logic [7:0]                   stat,
        input logic [7:0]                   temp
    );
        scp_pkg::scp_cmd_t r;
        logic [7:0]  c;
        logic [47:0] mhz;
        logic [47:0] frac;
        logic [47:0] scale;
        logic        dot;
        logic        ok;
        logic [47:0] dig;
        int          n;
        int          top;
        r     = '0;
        dig   = '0;
        mhz   = '0;
        frac  = '0;
        scale = scp_pkg::HZ_PER_MHZ;
        dot   = 1'b0;
        ok    = 1'b1;
        n     = int'(nbits) / scp_pkg::CHAR_W;
        // First character sits just below the newest bit count; a
        // trailing partial character is left out of the count
        top   = int'(nbits) - 1;
        c     = scp_upper(buf_in[top -: 8]);
        if (n == 1 && c == scp_pkg::CH_Q) begin
            r.reply_valid = 1'b1;
            r.reply[scp_pkg::BUF_W-1 -: 8] = stat;
        end else if (n == 1 && c == scp_pkg::CH_T) begin
            r.reply_valid = 1'b1;
            r.reply[scp_pkg::BUF_W-1 -: 8] = temp;
        end else if (n >= 2 && c == scp_pkg::CH_F) begin
            for (int i = 1; i < scp_pkg::MAX_CHARS; i++) begin
                if (i < n) begin
                    c = buf_in[top - 8*i -: 8];
                    if (c == scp_pkg::CH_DOT && !dot) begin
                        dot = 1'b1;
                    end else if (c >= scp_pkg::CH_ZERO
                                 && c <= scp_pkg::CH_NINE) begin
                        dig = 48'(c - scp_pkg::CH_ZERO);
                        if (!dot) begin
                            mhz = 48'(mhz * 48'd10 + dig);
                        end else if (scale > 48'd1) begin
                            scale = scale / 48'd10;
                            frac  = 48'(frac + scale * dig);
                        end
                    end else begin
                        ok = 1'b0;
                    end
                end
            end
            r.freq_valid = ok;
            r.freq_hz    = 48'(mhz * scp_pkg::HZ_PER_MHZ + frac);
        end
        return r;
    endfunction : scp_decode

    ////////////////////////////////////////////////////////////////////
    // Synchronised link, buffers, counters and their next values
    scp_pkg::scp_link_t lnk;
    scp_pkg::scp_cmd_t  cmd;
    scp_state_t         state, next_state;
    logic                          sclk_d, sel_d;
    logic [scp_pkg::BUF_W-1:0]     rx_buf, next_rx_buf;
    logic [scp_pkg::BUF_W-1:0]     tx_buf, next_tx_buf;
    logic [scp_pkg::BITCNT_W-1:0]  nbits, next_nbits;
    logic [15:0]                   hk_cnt, next_hk_cnt;
    logic                          next_sdo, next_freq_load, next_busy;
    logic [scp_pkg::FREQ_W-1:0]    next_freq_hz;
    logic                          lock_s1;
    logic                          sclk_rise, sel_fall, sel_rise;

    // Link lines through two flops each
    scp_sync #(.W(3)) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in ({~sel_n, sclk, sdi}),
        .sync_out ({lnk.sel, lnk.sclk, lnk.sdi})
    );

    // Edges from synchronised samples; sel is the active-high select
    assign sclk_rise = lnk.sclk && !sclk_d;
    assign sel_fall  = lnk.sel && !sel_d;
    assign sel_rise  = !lnk.sel && sel_d;
    assign cmd       = scp_decode(rx_buf, nbits, status_bits, temp_char);

    ////////////////////////////////////////////////////////////////////
    // Next-state logic of the port
    always_comb begin
        next_state     = state;
        next_rx_buf    = rx_buf;
        next_tx_buf    = tx_buf;
        next_nbits     = nbits;
        next_hk_cnt    = hk_cnt;
        next_sdo       = sdo;
        next_freq_load = 1'b0;
        next_freq_hz   = freq_hz;
        case (state)
            SCP_IDLE: begin
                next_sdo = 1'b0;
                // A select taken during housekeeping is lost: no edge here
                if (sel_fall) begin
                    next_state = SCP_RECV;
                    next_nbits = '0;
                    next_sdo   = 1'b1;
                end
            end
            SCP_RECV: begin
                if (sel_rise) begin
                    next_state = SCP_EXEC;
                    next_sdo   = 1'b0;
                end else if (sclk_rise) begin
                    // Bits past the buffer length are dropped, not wrapped
                    if (nbits < 8'(scp_pkg::BUF_W)) begin
                        next_rx_buf = {rx_buf[scp_pkg::BUF_W-2:0], lnk.sdi};
                        next_nbits  = nbits + 8'd1;
                    end
                    // Reply leaves MSB first, one bit per rising edge
                    next_sdo    = tx_buf[scp_pkg::BUF_W-1];
                    next_tx_buf = {tx_buf[scp_pkg::BUF_W-2:0], 1'b0};
                end
            end
            SCP_EXEC: begin
                if (cmd.freq_valid) begin
                    next_freq_hz   = cmd.freq_hz;
                    next_freq_load = 1'b1;
                end
                if (cmd.reply_valid) begin
                    next_tx_buf = cmd.reply;
                end
                // Other strings leave frequency and reply buffer as is
                next_state  = SCP_HK;
                next_hk_cnt = 16'(HK_CYCLES);
            end
            SCP_HK: begin
                // Busy stays up for a fixed span so a polite host waits
                next_sdo = 1'b0;
                if (hk_cnt <= 16'd1) begin
                    next_state = SCP_IDLE;
                end else begin
                    next_hk_cnt = hk_cnt - 16'd1;
                end
            end
            default: begin
                next_state = SCP_IDLE;
            end
        endcase
        // Busy while selected, interpreting or housekeeping
        next_busy = (next_state != SCP_IDLE) || lnk.sel;
    end

    // Registers of the port
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state     <= SCP_IDLE;
            rx_buf    <= '0;
            tx_buf    <= '0;
            nbits     <= '0;
            hk_cnt    <= '0;
            sdo       <= 1'b0;
            busy      <= 1'b0;
            freq_load <= 1'b0;
            freq_hz   <= '0;
            sclk_d    <= 1'b0;
            sel_d     <= 1'b0;
            lock_s1   <= 1'b0;
            lock      <= 1'b0;
        end else begin
            state     <= next_state;
            rx_buf    <= next_rx_buf;
            tx_buf    <= next_tx_buf;
            nbits     <= next_nbits;
            hk_cnt    <= next_hk_cnt;
            sdo       <= next_sdo;
            busy      <= next_busy;
            freq_load <= next_freq_load;
            freq_hz   <= next_freq_hz;
            sclk_d    <= lnk.sclk;
            sel_d     <= lnk.sel;
            // Lock level passes two flops of its own
            lock_s1   <= pll_locked;
            lock      <= lock_s1;
        end
    end

endmodule : scp_port

// ---- hdl/scp_sync.sv ----
// Purpose: Two-stage synchroniser for the link lines.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes:   First stage feeds only the second stage.
module scp_sync #(
    parameter int W = 3
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    // Shift the samples one stage
    always_comb begin
        next_meta = async_in;
        next_sync = meta;
    end

    // Stages reset to zero, so callers feed lines whose idle level is low
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= next_meta;
            sync_out <= next_sync;
        end
    end

endmodule : scp_sync
